// ---- fcps_defs.vh ----
// constants for the fault clear, write lock and config store block
`ifndef FCPS_DEFS_VH
`define FCPS_DEFS_VH

// =============================================================
// command codes
`define FCPS_CMD_PAGE        8'h00
`define FCPS_CMD_OPERATION   8'h01
`define FCPS_CMD_ON_OFF_CFG  8'h02
`define FCPS_CMD_CLEAR       8'h03
`define FCPS_CMD_WRITE_LOCK  8'h10
`define FCPS_CMD_STORE_DFLT  8'h11
`define FCPS_CMD_RESTORE_DFLT 8'h12
`define FCPS_CMD_SAVE_CFG    8'hee
`define FCPS_CMD_LOAD_CFG    8'hef

// =============================================================
// write_lock_level values
`define FCPS_LOCK_ALL        8'h80
`define FCPS_LOCK_OP_PAGE    8'h40
`define FCPS_LOCK_ONOFF      8'h20
`define FCPS_LOCK_NONE       8'h00
`define FCPS_LOCK_RESET      8'h00

// =============================================================
// flash array codes carried by the vendor store / restore byte
`define FCPS_CODE_MAIN       8'h00
`define FCPS_CODE_FLASH_ARRAY_A     8'h01
`define FCPS_SEL_MAIN        1'b0
`define FCPS_SEL_FLASH_ARRAY_A      1'b1

// =============================================================
// flash operations
`define FCPS_FOP_IDLE        2'h0
`define FCPS_FOP_CHECK       2'h1
`define FCPS_FOP_LOAD        2'h2
`define FCPS_FOP_STORE       2'h3

// =============================================================
// status bit positions
`define FCPS_CML_MAIN_BAD    1
`define FCPS_CML_FLASH_ARRAY_A_BAD  2
`define FCPS_VST_POR         0
`define FCPS_VST_WDOG        1
`define FCPS_OP_ON_BIT       7
`define FCPS_VST_RESET       8'h01

`endif

// ---- fcps_core.v ----
// fault clear, write lock and configuration store command interpreter
`timescale 1ns/1ns
// What this block does
// (RULE1) clear command wipes all latched status, drops alert
// (RULE2) clear also wipes power-on and watchdog flags
// (RULE3) clear never touches supply enables
// (RULE4) persisting fault relatches without alert
// (RULE5) reads always allowed whatever the lock
// (RULE6) lock 80h/40h/20h allow only listed commands
// (RULE7) lock 00h allows all, default value
// (RULE8) locked writes dropped silently, no flags
// (RULE9) bus writes go to working RAM only
// (RULE10) store default copies config RAM to main
// (RULE11) store failure sets summary bit and alert
// (RULE12) during store ignore commands, suspend monitoring
// (RULE13) restore checks main, on corruption flag, use flash_array_a
// (RULE14) flash_array_a also bad: flag, fault out, null state
// (RULE15) default restore runs automatically after reset
// (RULE16) host restores only with supplies off
// (RULE17) vendor store code 00h main, 01h flash_array_a
// (RULE18) vendor restore code 00h main, 01h flash_array_a
// (RULE19) vendor restore 01h only flags a corrupt array; 00h runs the default restore
// (RULE20) host recovers by write, store, reset
`include "fcps_defs.vh"

module fcps_core (
    input  wire       ref_clk,
    input  wire       arst_n,
    // decoded bus commands
    input  wire       cmd_valid,
    input  wire [7:0] cmd_code,
    input  wire       cmd_has_data,
    input  wire [7:0] cmd_data,
    output wire       cmd_ready,
    // bus reads
    input  wire [7:0] rd_code,
    output wire [7:0] ram_rd_addr,
    input  wire [7:0] ram_rd_data,
    output reg  [7:0] rd_data_q,
    // working configuration RAM write port
    output reg        ram_wr_en_q,
    output reg  [7:0] ram_wr_addr_q,
    output reg  [7:0] ram_wr_data_q,
    // flash engine handshake
    output wire       flash_req,
    output wire [1:0] flash_op,
    output wire       flash_sel,
    input  wire       flash_ack,
    input  wire       flash_err,
    // monitored conditions
    input  wire [7:0] fault_now,
    input  wire       wdog_event,
    input  wire       alert_enable,
    input  wire       supply_control_in,
    output wire       monitor_suspend,
    // status and pins
    output reg  [7:0] fault_status_q,
    output reg  [7:0] cml_status_q,
    output reg        cml_summary_q,
    output reg  [7:0] vendor_status_q,
    output reg  [7:0] write_lock_level_q,
    output reg        alert_q,
    output reg        supply_enable_out_q,
    output reg        fault_out_q,
    output reg        pins_hiz_q
);

    // =============================================================
    // states
    localparam ST_IDLE  = 3'd0;
    localparam ST_CHK_M = 3'd1;
    localparam ST_CHK_B = 3'd2;
    localparam ST_LOAD  = 3'd3;
    localparam ST_STORE = 3'd4;
    localparam ST_NULL  = 3'd5;

    reg  [2:0] state_q;
    reg  [2:0] state_d;
    reg        sel_q;
    reg        sel_d;
    reg        dflt_q;
    reg        dflt_d;
    reg  [7:0] fault_prev_q;
    reg        op_on_q;
    reg        latched_off_q;

    wire       accept;
    wire       allowed;
    wire       is_clear;
    wire       is_lock;
    wire       go_store_m;
    wire       go_store_b;
    wire       go_rest_m;
    wire       go_rest_b;
    wire [7:0] seen;
    wire [7:0] new_fault;
    wire       store_fail;

    // =============================================================
    // command acceptance and write lock
    // busy during any flash transfer, so commands are not taken
    assign cmd_ready = (state_q == ST_IDLE);           // see (RULE12)
    assign accept    = cmd_valid & cmd_ready;
    assign is_lock   = (cmd_code == `FCPS_CMD_WRITE_LOCK);

    // lock level decides which codes may be written
    assign allowed =
        is_lock ? 1'b1 :
        (write_lock_level_q == `FCPS_LOCK_ALL) ? 1'b0 :   // see (RULE6)
        (write_lock_level_q == `FCPS_LOCK_OP_PAGE) ?
            (cmd_code == `FCPS_CMD_OPERATION ||
             cmd_code == `FCPS_CMD_PAGE) :
        (write_lock_level_q == `FCPS_LOCK_ONOFF) ?
            (cmd_code == `FCPS_CMD_OPERATION ||
             cmd_code == `FCPS_CMD_PAGE ||
             cmd_code == `FCPS_CMD_ON_OFF_CFG) :
        1'b1;                                         // see (RULE7)

    // a refused write just falls through here, nothing is flagged
    assign is_clear   = accept & allowed &
                        (cmd_code == `FCPS_CMD_CLEAR);   // see (RULE8)
    assign go_store_m = accept & allowed &
        ((cmd_code == `FCPS_CMD_STORE_DFLT) |
         (cmd_code == `FCPS_CMD_SAVE_CFG & cmd_has_data &
          cmd_data == `FCPS_CODE_MAIN));               // see (RULE17)
    assign go_store_b = accept & allowed &
        (cmd_code == `FCPS_CMD_SAVE_CFG) & cmd_has_data &
        (cmd_data == `FCPS_CODE_FLASH_ARRAY_A);
    assign go_rest_m  = accept & allowed &
        ((cmd_code == `FCPS_CMD_RESTORE_DFLT) |
         (cmd_code == `FCPS_CMD_LOAD_CFG & cmd_has_data &
          cmd_data == `FCPS_CODE_MAIN));               // see (RULE18)
    assign go_rest_b  = accept & allowed &
        (cmd_code == `FCPS_CMD_LOAD_CFG) & cmd_has_data &
        (cmd_data == `FCPS_CODE_FLASH_ARRAY_A);

    // =============================================================
    // write lock register
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            write_lock_level_q <= `FCPS_LOCK_RESET;     // see (RULE7)
        end else if (accept & is_lock & cmd_has_data) begin
            write_lock_level_q <= cmd_data;
        end
    end

    // =============================================================
    // working RAM write port; flash is only reached by the engine
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ram_wr_en_q   <= 1'b0;
            ram_wr_addr_q <= 8'h00;
            ram_wr_data_q <= 8'h00;
        end else begin
            // data-carrying writes other than write lock and transfer codes
            ram_wr_en_q <= accept & allowed & cmd_has_data & ~is_lock &
                           (cmd_code != `FCPS_CMD_SAVE_CFG) &
                           (cmd_code != `FCPS_CMD_LOAD_CFG); // see (RULE9)
            if (accept & allowed & cmd_has_data) begin
                ram_wr_addr_q <= cmd_code;
                ram_wr_data_q <= cmd_data;
            end
        end
    end

    // =============================================================
    // reads are never gated by the lock
    assign ram_rd_addr = rd_code;
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_q <= 8'h00;
        end else if (rd_code == `FCPS_CMD_WRITE_LOCK) begin
            rd_data_q <= write_lock_level_q;             // see (RULE5)
        end else begin
            rd_data_q <= ram_rd_data;
        end
    end

    // =============================================================
    // flash transfer sequencer; reset lands in the main check
    assign flash_req = (state_q == ST_CHK_M) | (state_q == ST_CHK_B) |
                       (state_q == ST_LOAD)  | (state_q == ST_STORE);
    assign flash_op  = (state_q == ST_STORE) ? `FCPS_FOP_STORE :
                       (state_q == ST_LOAD)  ? `FCPS_FOP_LOAD  :
                       flash_req ? `FCPS_FOP_CHECK : `FCPS_FOP_IDLE;
    assign flash_sel = sel_q;
    // store copies only the config image; status never leaves here
    assign store_fail = (state_q == ST_STORE) & flash_ack & flash_err;
    assign monitor_suspend = (state_q == ST_STORE);    // see (RULE12)

    always @* begin
        state_d = state_q;
        sel_d   = sel_q;
        dflt_d  = dflt_q;
        case (state_q)
            ST_IDLE: begin
                if (go_store_m | go_store_b) begin
                    state_d = ST_STORE;                 // see (RULE10)
                    sel_d   = go_store_b;
                end else if (go_rest_m) begin
                    state_d = ST_CHK_M;                 // see (RULE13)
                    sel_d   = `FCPS_SEL_MAIN;
                    dflt_d  = 1'b1;
                end else if (go_rest_b) begin
                    state_d = ST_CHK_B;
                    sel_d   = `FCPS_SEL_FLASH_ARRAY_A;
                    dflt_d  = 1'b0;
                end
            end
            ST_CHK_M: begin
                if (flash_ack) begin
                    if (flash_err) begin
                        state_d = ST_CHK_B;              // see (RULE13)
                        sel_d   = `FCPS_SEL_FLASH_ARRAY_A;
                    end else begin
                        state_d = ST_LOAD;
                    end
                end
            end
            ST_CHK_B: begin
                if (flash_ack) begin
                    if (!flash_err) begin
                        state_d = ST_LOAD;
                    end else if (dflt_q) begin
                        state_d = ST_NULL;               // see (RULE14)
                    end else begin
                        state_d = ST_IDLE;               // see (RULE19)
                    end
                end
            end
            ST_LOAD: begin
                if (flash_ack) begin
                    state_d = ST_IDLE;
                end
            end
            ST_STORE: begin
                if (flash_ack) begin
                    state_d = ST_IDLE;
                end
            end
            ST_NULL: begin
                state_d = ST_NULL;                       // held until reset
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_CHK_M;                         // see (RULE15)
            sel_q   <= `FCPS_SEL_MAIN;
            dflt_q  <= 1'b1;
        end else begin
            state_q <= state_d;
            sel_q   <= sel_d;
            dflt_q  <= dflt_d;
        end
    end

    // =============================================================
    // fault latching; monitoring stops while a store runs
    assign seen      = monitor_suspend ? 8'h00 : fault_now;
    assign new_fault = seen & ~fault_prev_q;

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_prev_q   <= 8'h00;
            fault_status_q <= 8'h00;
        end else begin
            // held while suspended, so a standing fault is not new after
            if (!monitor_suspend) begin
                fault_prev_q <= seen;
            end
            // a still-present fault re-latches right after the clear
            if (is_clear) begin
                fault_status_q <= seen;                  // see (RULE4)
            end else begin
                fault_status_q <= fault_status_q | seen; // see (RULE1)
            end
        end
    end

    // =============================================================
    // memory, logic and vendor status; set wins over clear
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cml_status_q    <= 8'h00;
            cml_summary_q   <= 1'b0;
            vendor_status_q <= `FCPS_VST_RESET;          // power-on flag up
        end else begin
            if (is_clear) begin
                cml_status_q    <= 8'h00;                // see (RULE1)
                cml_summary_q   <= 1'b0;
                vendor_status_q <= 8'h00;                // see (RULE2)
            end
            if (state_q == ST_CHK_M && flash_ack && flash_err) begin
                cml_status_q[`FCPS_CML_MAIN_BAD] <= 1'b1; // see (RULE13)
            end
            if (state_q == ST_CHK_B && flash_ack && flash_err) begin
                cml_status_q[`FCPS_CML_FLASH_ARRAY_A_BAD] <= 1'b1; // see (RULE19)
            end
            // summary only; no detail bit for a failed store
            if (store_fail) begin
                cml_summary_q <= 1'b1;                   // see (RULE11)
            end
            if (wdog_event) begin
                vendor_status_q[`FCPS_VST_WDOG] <= 1'b1;
            end
        end
    end

    // =============================================================
    // alert: only fresh events raise it, the clear drops it
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            alert_q <= 1'b0;
        end else if (alert_enable & ((|new_fault) | store_fail)) begin
            alert_q <= 1'b1;                             // see (RULE11)
        end else if (is_clear) begin
            alert_q <= 1'b0;                             // see (RULE1)
        end
    end

    // =============================================================
    // supply enable: operation byte and control input, latched off by a new fault
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            op_on_q       <= 1'b0;
            latched_off_q <= 1'b0;
        end else begin
            if (accept & allowed & cmd_has_data &
                cmd_code == `FCPS_CMD_OPERATION) begin
                op_on_q       <= cmd_data[`FCPS_OP_ON_BIT];
                latched_off_q <= 1'b0;                   // see (RULE3)
            end
            // a fault in the same cycle as an operation write still wins
            if (|new_fault) begin
                latched_off_q <= 1'b1;
            end
        end
    end

    // =============================================================
    // output pins; null state releases all but the bus and fault pins
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            supply_enable_out_q <= 1'b0;
            fault_out_q         <= 1'b0;
            pins_hiz_q          <= 1'b0;
        end else begin
            supply_enable_out_q <= op_on_q & supply_control_in &
                                   ~latched_off_q &
                                   (state_q != ST_NULL); // see (RULE3)
            fault_out_q <= (state_q == ST_NULL);         // see (RULE14)
            pins_hiz_q  <= (state_q == ST_NULL);
        end
    end

endmodule

// ---- fcps_checker.sv ----
// assertion checker for the config store block
`timescale 1ns/1ns
module fcps_checker (
    input wire       ref_clk,
    input wire       arst_n,
    input wire       cmd_valid,
    input wire [7:0] cmd_code,
    input wire       cmd_ready,
    input wire [7:0] rd_code,
    input wire [7:0] rd_data_q,
    input wire       ram_wr_en_q,
    input wire       flash_req,
    input wire [1:0] flash_op,
    input wire       flash_sel,
    input wire       flash_ack,
    input wire       flash_err,
    input wire [7:0] fault_now,
    input wire       monitor_suspend,
    input wire [7:0] cml_status_q,
    input wire       cml_summary_q,
    input wire [7:0] write_lock_level_q,
    input wire       alert_q,
    input wire       fault_out_q,
    input wire       pins_hiz_q
);
    // ==========================================================
    // one domain, so clock and reset are given once
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    wire take = cmd_valid && cmd_ready;
    wire fdone = flash_req && flash_ack;

    a_busy_no_cmd: assert property (flash_req |-> !cmd_ready)
        else $error("command port open while flash busy");
    a_store_suspend: assert property (
        flash_req && flash_op == 2'h3 |-> monitor_suspend)
        else $error("monitoring not suspended during store");
    a_lock_all_drop: assert property (
        take && write_lock_level_q == 8'h80 && cmd_code != 8'h10
        |=> !ram_wr_en_q)
        else $error("write passed full lock");
    a_store_fail_flag: assert property (
        fdone && flash_op == 2'h3 && flash_err
        |=> cml_summary_q && cml_status_q == $past(cml_status_q))
        else $error("store failure not reported as summary only");
    a_main_bad_fall: assert property (
        fdone && flash_op == 2'h1 && !flash_sel && flash_err
        |=> cml_status_q[1])
        else $error("main corruption not flagged");
    a_flash_array_a_bad_flag: assert property (
        fdone && flash_op == 2'h1 && flash_sel && flash_err
        |=> cml_status_q[2])
        else $error("flash_array_a corruption not flagged");
    a_null_holds: assert property (
        pins_hiz_q |=> pins_hiz_q && fault_out_q && !cmd_ready)
        else $error("null state left or fault output low");
    a_lock_read: assert property (
        rd_code == 8'h10 |=> rd_data_q == $past(write_lock_level_q))
        else $error("lock level read wrong");
    a_clear_alert: assert property (
        take && cmd_code == 8'h03 && write_lock_level_q == 8'h00
        && (fault_now & ~$past(fault_now)) == 8'h00
        |=> !alert_q && !cml_summary_q && cml_status_q == 8'h00)
        else $error("clear left status or alert");
endmodule
bind fcps_core fcps_checker chk (.ref_clk(ref_clk), .arst_n(arst_n),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_ready(cmd_ready),
    .rd_code(rd_code), .rd_data_q(rd_data_q), .ram_wr_en_q(ram_wr_en_q),
    .flash_req(flash_req), .flash_op(flash_op), .flash_sel(flash_sel),
    .flash_ack(flash_ack), .flash_err(flash_err), .fault_now(fault_now),
    .monitor_suspend(monitor_suspend), .cml_status_q(cml_status_q),
    .cml_summary_q(cml_summary_q), .write_lock_level_q(write_lock_level_q),
    .alert_q(alert_q), .fault_out_q(fault_out_q), .pins_hiz_q(pins_hiz_q));

// ---- fcps_flash_model.sv ----
// flash array model answering the block's flash requests
`timescale 1ns/1ns
module fcps_flash_model (
    input  wire       ref_clk,
    input  wire       arst_n,
    input  wire       flash_req,
    input  wire [1:0] flash_op,
    input  wire       flash_sel,
    input  wire [3:0] delay,
    input  wire       bad_main,
    input  wire       bad_flash_array_a,
    input  wire       store_fail,
    output reg        flash_ack,
    output reg        flash_err
);
    reg [3:0] cnt_q;
    // one ack pulse after delay cycles; err is junk when no ack
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 4'h0;
            flash_ack <= 1'b0;
            flash_err <= 1'b0;
        end else if (flash_req && !flash_ack && cnt_q == delay) begin
            cnt_q <= 4'h0;
            flash_ack <= 1'b1;
            // validity per array, store result on its own
            flash_err <= flash_op == 2'h3 ? store_fail : flash_op == 2'h1
                ? (flash_sel ? bad_flash_array_a : bad_main) : 1'b0;
        end else begin
            cnt_q <= flash_req && !flash_ack ? cnt_q + 4'h1 : 4'h0;
            flash_ack <= 1'b0;
            flash_err <= ~flash_err;
        end
    end
endmodule

// ---- tb_top.sv ----
// self-checking bench for the config store block
`timescale 1ns/1ns
module tb_top;
    reg        ref_clk = 1'b0, arst_n = 1'b0, cmd_valid = 1'b0;
    reg        cmd_has_data = 1'b0, wdog_event = 1'b0, alert_enable = 1'b1;
    reg        supply_control_in = 1'b1, bad_main = 1'b0, bad_flash_array_a = 1'b0;
    reg        store_fail = 1'b0, last_sel = 1'b0, s;
    reg  [7:0] cmd_code = 8'h00, cmd_data = 8'h00, rd_code = 8'h00;
    reg  [7:0] fault_now = 8'h00, lock = 8'h00, n0;
    reg  [3:0] delay = 4'h2;
    reg [15:0] e;
    integer    n_errors = 0, cmp_count = 0, n_acks = 0, i;
    reg [15:0] exp_q[$];
    wire       cmd_ready, ram_wr_en_q, flash_req, flash_sel, flash_ack;
    wire       flash_err, monitor_suspend, cml_summary_q, alert_q;
    wire       supply_enable_out_q, fault_out_q, pins_hiz_q;
    wire [7:0] ram_rd_addr, rd_data_q, ram_wr_addr_q, ram_wr_data_q;
    wire [7:0] fault_status_q, cml_status_q, vendor_status_q;
    wire [7:0] write_lock_level_q;
    wire [1:0] flash_op;

    fcps_core dut (.ref_clk(ref_clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_has_data(cmd_has_data), .cmd_data(cmd_data),
        .cmd_ready(cmd_ready), .rd_code(rd_code), .ram_rd_addr(ram_rd_addr),
        .ram_rd_data(~ram_rd_addr), .rd_data_q(rd_data_q),
        .ram_wr_en_q(ram_wr_en_q), .ram_wr_addr_q(ram_wr_addr_q),
        .ram_wr_data_q(ram_wr_data_q), .flash_req(flash_req),
        .flash_op(flash_op), .flash_sel(flash_sel), .flash_ack(flash_ack),
        .flash_err(flash_err), .fault_now(fault_now), .wdog_event(wdog_event),
        .alert_enable(alert_enable), .supply_control_in(supply_control_in),
        .monitor_suspend(monitor_suspend), .fault_status_q(fault_status_q),
        .cml_status_q(cml_status_q), .cml_summary_q(cml_summary_q),
        .vendor_status_q(vendor_status_q), .alert_q(alert_q),
        .write_lock_level_q(write_lock_level_q), .fault_out_q(fault_out_q),
        .supply_enable_out_q(supply_enable_out_q), .pins_hiz_q(pins_hiz_q));
    fcps_flash_model fm (.ref_clk(ref_clk), .arst_n(arst_n),
        .flash_req(flash_req), .flash_op(flash_op), .flash_sel(flash_sel),
        .delay(delay), .bad_main(bad_main), .bad_flash_array_a(bad_flash_array_a),
        .store_fail(store_fail), .flash_ack(flash_ack), .flash_err(flash_err));

    // ==========================================================
    // helpers
    always #2 ref_clk = ~ref_clk;
    task check(input [7:0] seen, input [7:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("Error at %0t: seen %h expected %h", $time,
                    seen, exp);
            end
        end
    endtask
    // request held until a negedge shows ready, then taken at the edge
    task send(input [7:0] c, input h, input [7:0] d);
        begin
            @(posedge ref_clk);
            cmd_valid <= 1'b1;
            cmd_code <= c;
            cmd_has_data <= h;
            cmd_data <= d;
            @(negedge ref_clk);
            while (cmd_ready !== 1'b1) @(negedge ref_clk);
            @(posedge ref_clk);
            cmd_valid <= 1'b0;
        end
    endtask
    // note the ram write only when the lock lets it through
    task wr(input [7:0] c, input [7:0] d);
        begin
            if (lock == 8'h80 ? 0 : lock == 8'h40 ? c < 8'h02
                : lock == 8'h20 ? c < 8'h03 : 1)
                exp_q.push_back({c, d});
            send(c, 1'b1, d);
        end
    endtask
    task idle;
        begin
            @(negedge ref_clk);
            while (cmd_ready !== 1'b1) @(negedge ref_clk);
        end
    endtask
    task finish_test;
        begin
            $display("compares %0d mismatches %0d", cmp_count, n_errors);
            if (n_errors == 0 && cmp_count > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // monitors sample at negedge, clear of the launching edge
    always @(negedge ref_clk) begin
        if (flash_req && flash_ack === 1'b1) begin
            n_acks = n_acks + 1;
            last_sel = flash_sel;
        end
        if (ram_wr_en_q === 1'b1 && ram_wr_addr_q !== 8'h10) begin
            e = exp_q.size() ? exp_q.pop_front() : 16'hxxxx;
            check(ram_wr_addr_q, e[15:8]);
            check(ram_wr_data_q, e[7:0]);
        end
    end
    initial begin
        #200000;
        n_errors = n_errors + 1;
        finish_test;
    end

    // ==========================================================
    // tests
    initial begin
        i = $urandom(32'he68f);
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        idle;
        check(write_lock_level_q, 8'h00);
        check(vendor_status_q, 8'h01);
        check(8'(n_acks), 8'h02);
        $display("test reset done");
        n0 = 8'(n_acks);
        for (i = 0; i < 4; i = i + 1) begin
            lock = i == 0 ? 8'h80 : i == 1 ? 8'h40 : i == 2 ? 8'h20 : 8'h00;
            send(8'h10, 1'b1, lock);
            rd_code <= 8'h10;
            repeat (2) @(negedge ref_clk);
            check(rd_data_q, lock);
            wr(8'h00, 8'($urandom));
            wr(8'h01, 8'h80);
            wr(8'h02, 8'($urandom));
            wr(8'h20 + 8'($urandom % 96), 8'($urandom));
            send(8'h03, 1'b0, 8'h00);
            @(posedge ref_clk);
            rd_code <= 8'h37;
            repeat (2) @(negedge ref_clk);
            check(rd_data_q, 8'hc8);
            check({alert_q, cml_summary_q, cml_status_q[5:0]},
                8'h00);
            check(vendor_status_q, {7'h00, lock != 8'h00});
        end
        check(8'(n_acks), n0);
        $display("test lock done");
        @(posedge ref_clk);
        fault_now <= 8'h05;
        wdog_event <= 1'b1;
        @(posedge ref_clk);
        wdog_event <= 1'b0;
        repeat (3) @(negedge ref_clk);
        check({alert_q, 5'h00, vendor_status_q[1:0]}, 8'h82);
        s = supply_enable_out_q;
        send(8'h03, 1'b0, 8'h00);
        repeat (2) @(negedge ref_clk);
        check({alert_q, vendor_status_q[6:0]}, 8'h00);
        check(fault_status_q, 8'h05);
        check({7'h00, supply_enable_out_q}, {7'h00, s});
        @(posedge ref_clk);
        fault_now <= 8'h0d;
        repeat (3) @(negedge ref_clk);
        check({7'h00, alert_q}, 8'h01);
        @(posedge ref_clk);
        fault_now <= 8'h00;
        send(8'h03, 1'b0, 8'h00);
        repeat (2) @(negedge ref_clk);
        check(fault_status_q, 8'h00);
        $display("test clear done");
        for (i = 0; i < 4; i = i + 1) begin
            @(posedge ref_clk);
            delay <= 4'(3 + $urandom % 10);
            store_fail <= i < 2;
            alert_enable <= i != 1;
            send(i == 0 ? 8'h11 : 8'hee, i > 0, 8'(i - 1));
            idle;
            n0 = i == 0 ? 8'hc0 : i == 1 ? 8'h80 : 8'h20;
            check({cml_summary_q, alert_q, last_sel, cml_status_q[4:0]},
                n0);
            send(8'h03, 1'b0, 8'h00);
        end
        $display("test store done");
        // supplies are latched off here, as a restore wants
        for (i = 0; i < 4; i = i + 1) begin
            @(posedge ref_clk);
            bad_main <= i == 0;
            bad_flash_array_a <= i == 1;
            send(i < 3 ? 8'hef : 8'h12, i < 3, 8'(i * i));
            idle;
            n0 = i == 0 ? 8'h60 : i == 1 ? 8'ha0 : i == 2 ? 8'h20 : 8'h00;
            check({cml_status_q[2:1], last_sel, pins_hiz_q, 4'h0},
                n0);
            send(8'h03, 1'b0, 8'h00);
        end
        $display("test restore done");
        // both arrays bad: reset lands in null state; arrays good again: reset recovers
        for (i = 0; i < 2; i = i + 1) begin
            @(posedge ref_clk);
            bad_main <= i == 0;
            bad_flash_array_a <= i == 0;
            arst_n <= 1'b0;
            repeat (12) @(posedge ref_clk);
            arst_n <= 1'b1;
            repeat (80) @(negedge ref_clk);
            check({cml_status_q[2:1], pins_hiz_q, fault_out_q, cmd_ready,
                3'h0}, i ? 8'h08 : 8'hf0);
        end
        check(8'(exp_q.size()), 8'h00);
        $display("test null done");
        finish_test;
    end
endmodule
